// File: pbd_decoder.sv
// Serial paging stream decoder: preamble, batch sync, frames, address match.
//
// Behaviour
// [R1] Line high is logic zero, line low is logic one.
// [R2] Sender gives 576 alternating preamble bits at 512 or 1200 bps.
// [R3] Alternating preamble marks a valid stream and aligns bit sampling.
// [R4] After sync, count eight frames of two codewords, sixteen slots.
// [R5] Sender fills every frame with two codewords of any type.
// [R6] Fixed 32-bit sync word starts each batch and realigns counting.
// [R7] Receiver strobe stays on while the sync word is expected.
// [R8] First received bit zero marks an address codeword.
// [R9] Bits 2 to 19 form the address compared with own address.
// [R10] Bits 20 and 21 select one of four sources.
// [R11] Bits 22 to 31 are check bits, bit 32 even parity.
// [R12] Addresses are examined only in the configured three-bit frame.
// [R13] Receiver strobe is off in all other frames of the batch; the code keeps it on there while a message follows.
// [R14] Identity is 18 address bits above the three frame bits.
// [R15] First bit one marks a message codeword following a match.
// [R16] Exact idle pattern is recognised and carries no address.
// [R17] Sender pads a single-address frame with idle to 64 bits.
// [R18] Strobe drives the receiver regulator; mode lines set the demodulator.
// [R19] Pages are address plus numeric data; tone-only is not handled.
// [R20] Matching page words are passed to the host.
// [R21] Without preamble strobe on 217 ms or 93 ms every 1.047 s.
// [R22] On own address raise alert and keep decoding messages.
// [R23] Sync word matched is hexadecimal 7CD215D8.
// [R24] Bit 1 arrives first and bit 32 last.
`timescale 1ns/100ps
module pbd_decoder import pbd_pkg::*; #(
	parameter int unsigned BIT_CYCLES_512 = BIT_CYC_512,
	parameter int unsigned BIT_CYCLES_1200 = BIT_CYC_1200,
	parameter int unsigned SAVE_ON_512 = SAVE_ON_CYC_512,
	parameter int unsigned SAVE_ON_1200 = SAVE_ON_CYC_1200,
	parameter int unsigned SAVE_PERIOD = SAVE_PERIOD_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic rx_data,
	input wire logic rate_1200,
	input wire logic [17:0] own_address,
	input wire logic [2:0] own_frame,
	output logic rx_power_strobe,
	output logic [1:0] demod_mode,
	output logic page_alert,
	output logic [1:0] page_source,
	output logic [20:0] page_identity,
	output logic in_sync,
	output logic overflow,
	output logic host_valid,
	input wire logic host_ready,
	output logic [FIFO_W-1:0] host_data
);

	// ****************************************
	// Declarations.
	// ****************************************
	pbd_state_t state;
	logic sync1;
	logic sync2;
	logic sync3;
	logic line_level;
	logic line_prev;
	logic line_edge;
	logic bit_value;
	logic bit_tick;
	logic [31:0] bit_phase;
	logic [31:0] bit_len;
	logic [31:0] save_cnt;
	logic [31:0] save_on;
	logic save_window;
	logic [31:0] shreg;
	logic [31:0] next_shreg;
	logic prev_bit;
	logic [9:0] alt_cnt;
	logic [9:0] hunt_cnt;
	logic [5:0] bit_cnt;
	logic [4:0] slot;
	logic [2:0] frame;
	logic cw_done;
	logic own_slot;
	logic msg_follow;
	logic is_idle;
	logic is_addr;
	logic parity_ok;
	logic addr_hit;
	logic push_req;
	logic [FIFO_W-1:0] push_word;
	logic fifo_in_ready;

	// ****************************************
	// Line input and bit timing.
	// ****************************************

	// Three-stage synchroniser; a new level counts once stages two and three
	// agree, which also rejects single-sample glitches.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
			sync3 <= 1'b1;
		end else begin
			sync1 <= rx_data;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Filtered line level and its previous value for edge detection.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			line_level <= 1'b1;
			line_prev <= 1'b1;
		end else begin
			if (sync2 == sync3) begin
				line_level <= sync3;
			end
			line_prev <= line_level;
		end
	end

	assign line_edge = line_level != line_prev;
	assign bit_value = ~line_level; // R1
	assign bit_len = rate_1200 ? BIT_CYCLES_1200 : BIT_CYCLES_512;

	// Bit clock divider. Outside a batch every line edge pulls the sampling
	// point to mid-bit, so the alternating preamble trains the phase; inside a
	// batch the receiver may be off, so edges are ignored there.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			bit_phase <= CNT_RESET;
		end else if (line_edge && (state == ST_SEARCH || state == ST_HUNT)) begin
			bit_phase <= bit_len >> 1; // R3
		end else if (bit_phase == CNT_RESET) begin
			bit_phase <= bit_len - 32'd1;
		end else begin
			bit_phase <= bit_phase - 32'd1;
		end
	end

	assign bit_tick = (bit_phase == CNT_RESET);

	// ****************************************
	// Battery saver duty cycle.
	// ****************************************

	// Free-running period counter; only consulted while searching.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			save_cnt <= CNT_RESET;
		end else if (save_cnt >= SAVE_PERIOD - 1) begin
			save_cnt <= CNT_RESET;
		end else begin
			save_cnt <= save_cnt + 32'd1;
		end
	end

	assign save_on = rate_1200 ? SAVE_ON_1200 : SAVE_ON_512;
	assign save_window = save_cnt < save_on; // R21

	// ****************************************
	// Shift register and codeword fields.
	// ****************************************

	// Bit 1 enters first and ends at bit 31, bit 32 ends at bit 0.
	assign next_shreg = {shreg[30:0], bit_value}; // R24

	always_ff @(posedge clk) begin
		if (!resetn) begin
			shreg <= CNT_RESET;
			prev_bit <= 1'b0;
		end else if (bit_tick) begin
			shreg <= next_shreg;
			prev_bit <= bit_value;
		end
	end

	assign frame = slot[3:1];
	assign own_slot = (frame == own_frame);
	assign cw_done = bit_tick && (state == ST_BATCH) && (bit_cnt == CW_BITS - 6'd1);
	assign is_idle = (next_shreg == IDLE_WORD); // R16
	assign is_addr = !next_shreg[31] && !is_idle; // R8
	assign parity_ok = ~^next_shreg; // R11
	assign addr_hit = is_addr && parity_ok && own_slot
		&& (next_shreg[30:13] == own_address); // R9 R12

	// ****************************************
	// Sequencer.
	// ****************************************

	// Preamble run counter: consecutive alternating bits while listening.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			alt_cnt <= '0;
		end else if (state != ST_SEARCH || !save_window) begin
			alt_cnt <= '0;
		end else if (bit_tick) begin
			if (bit_value != prev_bit) begin
				alt_cnt <= alt_cnt + 10'd1;
			end else begin
				alt_cnt <= '0;
			end
		end
	end

	// Main state and counters. A missing sync word drops back to search,
	// which costs the rest of the stream until the next preamble.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state <= ST_SEARCH;
			hunt_cnt <= '0;
			bit_cnt <= '0;
			slot <= '0;
		end else if (bit_tick) begin
			case (state)
				ST_SEARCH: begin
					hunt_cnt <= '0;
					if (alt_cnt >= PRE_DET_BITS - 10'd1) begin
						state <= ST_HUNT; // R3
					end
				end
				ST_HUNT: begin
					if (next_shreg == BATCH_SYNC_WORD) begin
						state <= ST_BATCH; // R6 R23
						bit_cnt <= '0;
						slot <= '0;
					end else if (hunt_cnt == HUNT_BITS) begin
						state <= ST_SEARCH;
					end else begin
						hunt_cnt <= hunt_cnt + 10'd1;
					end
				end
				ST_BATCH: begin
					if (bit_cnt == CW_BITS - 6'd1) begin
						bit_cnt <= '0;
						if (slot == SLOTS_PER_BATCH - 5'd1) begin
							slot <= '0;
							state <= ST_SYNC; // R4
						end else begin
							slot <= slot + 5'd1;
						end
					end else begin
						bit_cnt <= bit_cnt + 6'd1;
					end
				end
				ST_SYNC: begin
					if (bit_cnt == CW_BITS - 6'd1) begin
						bit_cnt <= '0;
						if (next_shreg == BATCH_SYNC_WORD) begin
							state <= ST_BATCH; // R6
						end else begin
							state <= ST_SEARCH;
						end
					end else begin
						bit_cnt <= bit_cnt + 6'd1;
					end
				end
				default: begin
					state <= ST_SEARCH;
				end
			endcase
		end
	end

	// Message follow flag: set by an own address, held through message
	// codewords, ended by any idle or address word or by loss of sync.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			msg_follow <= 1'b0;
		end else if (state == ST_SEARCH) begin
			msg_follow <= 1'b0;
		end else if (cw_done) begin
			if (addr_hit) begin
				msg_follow <= 1'b1; // R22
			end else if (is_idle || is_addr) begin
				msg_follow <= 1'b0; // R15
			end
		end
	end

	// ****************************************
	// Page reporting.
	// ****************************************

	// Alert pulse, source selector and full identity of the latest match.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			page_alert <= 1'b0;
			page_source <= '0;
			page_identity <= '0;
		end else begin
			page_alert <= cw_done && addr_hit; // R22
			if (cw_done && addr_hit) begin
				page_source <= next_shreg[12:11]; // R10
				page_identity <= {next_shreg[30:13], own_frame}; // R14
			end
		end
	end

	// Words to the host: the matched address, then each message codeword.
	// Only address-plus-data pages exist here; a match with no message
	// following simply yields one address word.
	assign push_req = cw_done
		&& (addr_hit || (msg_follow && next_shreg[31] && !is_idle)); // R15 R19
	assign push_word = {(addr_hit ? KIND_ADDR : KIND_MSG), parity_ok,
		next_shreg}; // R20

	// The radio cannot be paused, so a full queue loses the word and leaves
	// a sticky overflow mark until reset.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			overflow <= 1'b0;
		end else if (push_req && !fifo_in_ready) begin
			overflow <= 1'b1;
		end
	end

	pbd_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_D)
	) u_fifo (
		.clk(clk),
		.resetn(resetn),
		.in_valid(push_req),
		.in_ready(fifo_in_ready),
		.in_data(push_word),
		.out_valid(host_valid),
		.out_ready(host_ready),
		.out_data(host_data)
	);

	// ****************************************
	// Receiver control.
	// ****************************************

	// Supply strobe: duty cycled while searching, on while hunting and across
	// the sync word, otherwise on only for the own frame or a running message.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rx_power_strobe <= 1'b1;
		end else begin
			case (state)
				ST_SEARCH: rx_power_strobe <= save_window; // R21 R18
				ST_HUNT: rx_power_strobe <= 1'b1;
				ST_SYNC: rx_power_strobe <= 1'b1; // R7
				default: rx_power_strobe <= own_slot || msg_follow; // R13
			endcase
		end
	end

	// Demodulator mode lines: fast acquisition until sync, tracking after.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			demod_mode <= MODE_ACQUIRE;
			in_sync <= 1'b0;
		end else begin
			demod_mode <= (state == ST_BATCH || state == ST_SYNC) ?
				MODE_TRACK : MODE_ACQUIRE; // R18
			in_sync <= (state == ST_BATCH || state == ST_SYNC);
		end
	end

endmodule : pbd_decoder

// File: pbd_decoder_properties.sv
// Port checker of the paging batch decoder, with its bind.
`timescale 1ns/100ps
module pbd_checker import pbd_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	input wire logic rx_power_strobe,
	input wire logic [1:0] demod_mode,
	input wire logic page_alert,
	input wire logic [20:0] page_identity,
	input wire logic [17:0] own_address,
	input wire logic [2:0] own_frame,
	input wire logic in_sync,
	input wire logic overflow,
	input wire logic host_valid,
	input wire logic host_ready,
	input wire logic [FIFO_W-1:0] host_data
);
	// ****
	// Checks.
	// ****
	// One domain, so one clock and one disable serve every check.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// Leaving reset, the receiver is powered and the decoder searches.
	AST_RESET_STATE: assert property ($rose(resetn) |->
		rx_power_strobe && demod_mode == MODE_ACQUIRE && !in_sync)
		else $error("outputs not at reset values");
	AST_ACQUIRE_MODE: assert property (
		!in_sync |-> demod_mode == MODE_ACQUIRE)
		else $error("wrong demodulator mode out of sync");
	AST_TRACK_MODE: assert property (
		in_sync |-> demod_mode == MODE_TRACK)
		else $error("wrong demodulator mode in sync");
	AST_ALERT_PULSE: assert property (page_alert |=> !page_alert)
		else $error("alert longer than one cycle");
	AST_ALERT_ID: assert property (
		page_alert |=> page_identity == {own_address, own_frame})
		else $error("identity wrong after alert");
	AST_ALERT_WORD: assert property (page_alert |=> host_valid)
		else $error("no host word after alert");
	AST_ALERT_SYNC: assert property (page_alert |-> in_sync)
		else $error("alert outside a batch");
	// The host may stall; a word must not change under it.
	AST_HOLD: assert property (
		host_valid && !host_ready |=> host_valid && $stable(host_data))
		else $error("host word dropped or changed");
	AST_PARITY: assert property (
		host_valid |-> host_data[32] == ~^host_data[31:0])
		else $error("parity flag wrong");
	AST_KIND: assert property (host_valid |->
		host_data[34:33] == (host_data[31] ? KIND_MSG : KIND_ADDR))
		else $error("codeword kind wrong");
	AST_OWN_ADDR: assert property (
		host_valid && !host_data[31] |-> host_data[30:13] == own_address)
		else $error("foreign address passed on");
	AST_NO_IDLE: assert property (
		host_valid |-> host_data[31:0] != IDLE_WORD)
		else $error("idle word passed on");
	AST_OVF_STICKY: assert property (overflow |=> overflow)
		else $error("overflow flag cleared");
endmodule : pbd_checker

bind pbd_decoder pbd_checker u_pbd_checker (.clk, .resetn,
	.rx_power_strobe, .demod_mode, .page_alert, .page_identity,
	.own_address, .own_frame, .in_sync, .overflow, .host_valid,
	.host_ready, .host_data);

// File: pbd_fifo.sv
// Word FIFO with registered read data between decoder and host.
`timescale 1ns/100ps
module pbd_fifo #(
	parameter int WIDTH = 35,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	// ****************************************
	// Handshake terms.
	// ****************************************
	// Full is honest: the output register does not count as free space.
	assign in_ready = (count != (AW + 1)'(DEPTH));
	assign push = in_valid && in_ready;
	assign pop = (count != '0) && (!out_valid || out_ready);

	// Storage array; written only, never reset.
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and fill level.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end

	// Output register stage; it holds a word until the host takes it.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			out_valid <= 1'b0;
			out_data <= '0;
		end else if (pop) begin
			out_valid <= 1'b1;
			out_data <= mem[rd_ptr];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end

endmodule : pbd_fifo

// File: pbd_pkg.sv
// Shared constants and types of the paging batch decoder.
package pbd_pkg;

	// ****************************************
	// Clock and bit timing.
	// ****************************************
	localparam int CLK_NS = 20;
	localparam int BIT_NS_512 = 1953125;
	localparam int BIT_NS_1200 = 833333;
	localparam int BIT_CYC_512 = BIT_NS_512 / CLK_NS;
	localparam int BIT_CYC_1200 = BIT_NS_1200 / CLK_NS;

	// ****************************************
	// Battery saver duty cycle without preamble.
	// ****************************************
	localparam int SAVE_ON_MS_512 = 217;
	localparam int SAVE_ON_MS_1200 = 93;
	localparam int SAVE_PERIOD_US = 1047000;
	localparam int SAVE_ON_CYC_512 = SAVE_ON_MS_512 * 1000000 / CLK_NS;
	localparam int SAVE_ON_CYC_1200 = SAVE_ON_MS_1200 * 1000000 / CLK_NS;
	localparam int SAVE_PERIOD_CYC = SAVE_PERIOD_US * 1000 / CLK_NS;

	// ****************************************
	// Stream structure.
	// ****************************************
	localparam logic [31:0] BATCH_SYNC_WORD = 32'h7CD215D8;
	localparam logic [31:0] IDLE_WORD = 32'h7A89C197;
	localparam logic [5:0] CW_BITS = 6'h20;
	localparam logic [4:0] SLOTS_PER_BATCH = 5'h10;
	localparam logic [9:0] PRE_DET_BITS = 10'h020;
	localparam logic [9:0] HUNT_BITS = 10'h280;

	// ****************************************
	// Reset values and output encodings.
	// ****************************************
	localparam logic [31:0] CNT_RESET = 32'h00000000;
	localparam logic [1:0] KIND_ADDR = 2'h0;
	localparam logic [1:0] KIND_MSG = 2'h1;
	localparam logic [1:0] MODE_ACQUIRE = 2'h1;
	localparam logic [1:0] MODE_TRACK = 2'h2;
	localparam int FIFO_W = 35;
	localparam int FIFO_D = 32;

	typedef enum logic [1:0] {
		ST_SEARCH = 2'b00,
		ST_HUNT = 2'b01,
		ST_BATCH = 2'b10,
		ST_SYNC = 2'b11
	} pbd_state_t;

endpackage : pbd_pkg

// File: pbd_tx_model.sv
// Demodulator model that sends the paging stream on the data line.
`timescale 1ns/100ps
module pbd_tx_model #(
	parameter int BITC = 8,
	parameter int BITC_512 = 16
) (
	input wire logic clk,
	input wire logic rate_1200,
	output logic rx_data
);
	// ****
	// Line driver.
	// ****
	// The line idles high, which reads as a run of zeros.
	initial rx_data = 1'b1;

	// One bit, inverted on the line, held a whole bit period. The period is
	// read only after the edge, so a rate change made just before counts.
	task automatic send_bit(input logic b);
		int n;
		@(negedge clk);
		n = (rate_1200 === 1'b1) ? BITC : BITC_512;
		rx_data <= ~b;
		repeat (n - 1) @(negedge clk);
	endtask : send_bit

	// Alternating preamble, starting with a one.
	task automatic send_preamble(input int n);
		for (int i = 0; i < n; i++)
			send_bit(~i[0]);
	endtask : send_preamble

	// A codeword goes out bit 1 first.
	task automatic send_word(input logic [31:0] w);
		for (int i = 31; i >= 0; i--)
			send_bit(w[i]);
	endtask : send_word

	// Back to idle level, held long enough for the decoder to finish.
	task automatic release_line();
		@(negedge clk);
		rx_data <= 1'b1;
		repeat (4 * BITC) @(negedge clk);
	endtask : release_line
endmodule : pbd_tx_model

// File: tb_pbd_decoder.sv
// Self-checking bench for the paging batch decoder.
`timescale 1ns/100ps
`define CHK(n, e, g) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		fail_count++; \
		$display("FAIL %s exp %0h got %0h", n, e, g); \
	end \
end
module tb_pbd_decoder import pbd_pkg::*;;
	// ****
	// Set-up.
	// ****
	// Short bit and saver counts keep the run brief.
	localparam int BITC = 8;
	localparam int BITC512 = 16;
	localparam int ON512 = 1200;
	localparam int ON1200 = 700;
	localparam int PER = 2000;
	localparam logic [17:0] ADDR = 18'h2A5C3;
	localparam logic [2:0] FRAME = 3'h2;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic rate_1200 = 1'b1;
	logic host_ready = 1'b1;
	logic [17:0] own_address = ADDR;
	logic [2:0] own_frame = FRAME;
	logic rx_data, rx_power_strobe, page_alert, in_sync;
	logic overflow, host_valid;
	logic [1:0] demod_mode, page_source;
	logic [20:0] page_identity;
	logic [FIFO_W-1:0] host_data;
	logic [FIFO_W-1:0] got[$];
	logic [31:0] slot[16];
	int alerts = 0;
	int fail_count = 0;
	int tests_run = 0;

	always #10 clk = ~clk;

	pbd_tx_model #(.BITC(BITC), .BITC_512(BITC512)) tx (.clk,
		.rate_1200, .rx_data);
	pbd_decoder #(.BIT_CYCLES_512(BITC512), .BIT_CYCLES_1200(BITC),
		.SAVE_ON_512(ON512), .SAVE_ON_1200(ON1200), .SAVE_PERIOD(PER)
	) dut (.clk, .resetn, .rx_data, .rate_1200, .own_address, .own_frame,
		.rx_power_strobe, .demod_mode, .page_alert, .page_source,
		.page_identity, .in_sync, .overflow, .host_valid, .host_ready,
		.host_data);

	// Host side: keep every word taken and count alert pulses.
	always @(posedge clk) begin
		if (host_valid === 1'b1 && host_ready === 1'b1)
			got.push_back(host_data);
		if (page_alert === 1'b1)
			alerts++;
	end

	// Codeword with zero check bits and even parity in bit 32.
	function automatic logic [31:0] cw(input logic m, input logic [19:0] f);
		logic [31:0] w;
		w = {m, f, 11'h000};
		w[0] = ^w[31:1];
		return w;
	endfunction : cw

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	// Sync word then sixteen slots, each looked at in its middle.
	task automatic send_batch(input logic [16:0] on, input logic [16:0] care);
		for (int k = 0; k < 17; k++) begin
			fork
				tx.send_word(k == 0 ? BATCH_SYNC_WORD : slot[k - 1]);
				begin
					repeat (16 * (rate_1200 ? BITC : BITC512))
						@(negedge clk);
					if (care[k])
						`CHK("strobe", on[k], rx_power_strobe)
					if (k > 0) begin
						`CHK("in_sync", 1'b1, in_sync)
						`CHK("mode", MODE_TRACK, demod_mode)
					end
				end
			join
		end
	endtask : send_batch

	task automatic t_reset();
		@(negedge clk);
		`CHK("strobe", 1'b1, rx_power_strobe)
		`CHK("mode", MODE_ACQUIRE, demod_mode)
		`CHK("in_sync", 1'b0, in_sync)
		`CHK("host_valid", 1'b0, host_valid)
		$display("reset test done");
	endtask : t_reset

	// Whole saver periods on a quiet line, at both rates.
	task automatic t_saver();
		int cnt;
		for (int r = 0; r < 2; r++) begin
			rate_1200 <= r[0];
			repeat (PER) @(negedge clk);
			cnt = 0;
			repeat (PER) begin
				@(negedge clk);
				cnt += int'(rx_power_strobe === 1'b1);
			end
			`CHK("saver on", r ? ON1200 : ON512, cnt)
		end
		$display("saver test done");
	endtask : t_saver

	// Own address out of frame and with bad parity, then a real page.
	// Runs at the slow rate so both bit timings carry a whole batch.
	task automatic t_page();
		for (int k = 0; k < 16; k++)
			slot[k] = IDLE_WORD;
		slot[0] = cw(1'b0, {ADDR, 2'h3});
		slot[4] = cw(1'b0, {ADDR, 2'h3}) ^ 32'h1;
		slot[5] = cw(1'b0, {ADDR, 2'h3});
		slot[6] = cw(1'b1, 20'h12345);
		slot[7] = cw(1'b1, 20'h6789A);
		rate_1200 <= 1'b0;
		got.delete();
		alerts = 0;
		tx.send_preamble(576);
		send_batch(17'h001E1, 17'h1FDFF);
		tx.send_word(IDLE_WORD);
		for (int i = 0; i < 99 && in_sync !== 1'b0; i++)
			@(negedge clk);
		`CHK("sync lost", 1'b0, in_sync)
		`CHK("words", 3, got.size())
		`CHK("addr word", {KIND_ADDR, 1'b1, slot[5]}, got[0])
		`CHK("msg word", {KIND_MSG, 1'b1, slot[6]}, got[1])
		`CHK("msg word", {KIND_MSG, 1'b1, slot[7]}, got[2])
		`CHK("identity", {ADDR, FRAME}, page_identity)
		`CHK("source", 2'h3, page_source)
		`CHK("alerts", 1, alerts)
		$display("page test done");
	endtask : t_page

	// Four batches while the host stalls, then a full drain.
	task automatic t_overflow();
		for (int k = 0; k < 16; k++)
			slot[k] = k < 4 ? IDLE_WORD : cw(1'b1, 20'(k));
		slot[4] = cw(1'b0, {~ADDR, 2'h0});
		slot[5] = cw(1'b0, {ADDR, 2'h1});
		rate_1200 <= 1'b1;
		host_ready <= 1'b0;
		got.delete();
		tx.send_preamble(576);
		repeat (4)
			send_batch(17'h1FFE1, 17'h1FFFD);
		tx.release_line();
		`CHK("overflow", 1'b1, overflow)
		host_ready <= 1'b1;
		for (int i = 0; i < 99 && host_valid !== 1'b0; i++)
			@(negedge clk);
		`CHK("drained", 33, got.size())
		`CHK("first", {KIND_ADDR, 1'b1, slot[5]}, got[0])
		`CHK("second", {KIND_MSG, 1'b1, slot[6]}, got[1])
		$display("overflow test done");
	endtask : t_overflow

	// Main sequence.
	initial begin
		repeat (6) @(negedge clk);
		resetn <= 1'b1;
		t_reset();
		t_saver();
		t_page();
		t_overflow();
		tally_and_finish();
	end

	// Cut a hang short; running out counts as a mismatch.
	initial begin
		repeat (100000) @(posedge clk);
		fail_count++;
		tally_and_finish();
	end
endmodule : tb_pbd_decoder
